// ===== design/tlab_pkg.sv
// package: command codes, field positions, reset values and helpers for the limit alert bank
package tlab_pkg;

    // ----------------------------------------
    // command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_INPUT_VOLTAGE_HIGH = 8'h04;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_LOW = 8'h05;
    localparam logic [7:0] CMD_OUTPUT_VOLTAGE_HIGH = 8'h06;
    localparam logic [7:0] CMD_INPUT_CURRENT_HIGH = 8'h07;
    localparam logic [7:0] CMD_BATTERY_CURRENT_LOW = 8'h08;
    localparam logic [7:0] CMD_CHIP_TEMPERATURE_HIGH = 8'h09;
    localparam logic [7:0] CMD_CELL_RESISTANCE_HIGH = 8'h0a;
    localparam logic [7:0] CMD_ALERT_ENABLE = 8'h0d;
    localparam logic [7:0] CMD_ALERT_FLAGS = 8'h0e;

    // ----------------------------------------
    // field positions, shared by enable and flag words
    // ----------------------------------------
    localparam int BIT_INPUT_VOLTAGE_HIGH = 8;
    localparam int BIT_OUTPUT_VOLTAGE_LOW = 7;
    localparam int BIT_OUTPUT_VOLTAGE_HIGH = 6;
    localparam int BIT_INPUT_CURRENT_HIGH = 5;
    localparam int BIT_BATTERY_CURRENT_LOW = 4;
    localparam int BIT_CHIP_TEMPERATURE_HIGH = 3;
    localparam int BIT_CELL_RESISTANCE_HIGH = 2;
    localparam int NUM_CH = 7;

    // ----------------------------------------
    // reset values and channel shape
    // ----------------------------------------
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_RESET = 16'h0000;
    localparam logic [15:0] ENABLE_MASK = 16'h01fc;
    // bit i is channel i; channel 0 is input voltage high, channel 6 cell resistance high
    localparam logic [6:0] CH_IS_HIGH = 7'h6d;
    localparam logic [6:0] CH_IS_SIGNED = 7'h3f;

    // ----------------------------------------
    // code weights, for reference by software models
    // ----------------------------------------
    localparam real INPUT_VOLTAGE_MV_PER_LSB = 1.649;
    localparam real OUTPUT_VOLTAGE_MV_PER_LSB = 1.653;
    localparam real CHIP_TEMPERATURE_C_PER_LSB = 0.0215;
    localparam real CHIP_TEMPERATURE_C_OFFSET = 264.4;
    localparam int CELL_RESISTANCE_DIVISOR = 500;

    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_ACK, ST_SEND, ST_MACK} tlab_state_type;

    // channel bit in the enable and flag words
    function automatic int ch_bit(input int ch);
        return BIT_INPUT_VOLTAGE_HIGH - ch;
    endfunction

    // true when the code is past the limit in the channel's direction
    function automatic logic crosses(input logic [15:0] code, input logic [15:0] limit,
                                     input logic is_high, input logic is_signed);
        logic gt;
        logic lt;
        gt = is_signed ? ($signed(code) > $signed(limit)) : (code > limit);
        lt = is_signed ? ($signed(code) < $signed(limit)) : (code < limit);
        return is_high ? gt : lt;
    endfunction

endpackage

// ===== design/tlab_i2c_edges.sv
// serial port line watcher: clock edges and start/stop conditions
`timescale 1ns/1ps
module tlab_i2c_edges
    import tlab_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_rise,
    output logic scl_fall,
    output logic start_seen,
    output logic stop_seen,
    output logic sda_q
);
    logic scl_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // sda may only move while scl is high to mark start or stop
    assign scl_rise = !scl_q && scl_in;
    assign scl_fall = scl_q && !scl_in;
    assign start_seen = scl_q && scl_in && sda_q && !sda_in;
    assign stop_seen = scl_q && scl_in && !sda_q && sda_in;
endmodule

// ===== design/tlab_alert_chan.sv
// one limit channel: compare on each fresh sample, sticky flag
`timescale 1ns/1ps
module tlab_alert_chan
    import tlab_pkg::*;
#(
    parameter logic IS_HIGH = 1'b1,
    parameter logic IS_SIGNED = 1'b1
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [15:0] code,
    input wire logic [15:0] limit,
    input wire logic sample,
    input wire logic enable,
    input wire logic clear,
    output logic flag_q
);
    logic hit;

    assign hit = sample && enable && crosses(code, limit, IS_HIGH, IS_SIGNED);

    // set wins over a clear in the same cycle so no crossing is lost
    always_ff @(posedge clk)
    begin
        if (rst)
            flag_q <= 1'b0;
        else
            flag_q <= hit || (flag_q && !clear);
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_flag_stays_set: assert property (flag_q && !clear |=> flag_q)
        else $error("alert flag dropped without a clear");
    a_flag_has_cause: assert property ($rose(flag_q) |-> $past(sample && enable))
        else $error("alert flag rose without an enabled sample");
endmodule

// ===== design/tlab_bank.sv
// limit alert bank top: serial command port, limit registers, enables, flags and alert line
`timescale 1ns/1ps
module tlab_bank
    import tlab_pkg::*;
#(
    // bus address; value is arbitrary
    parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out_q,
    output logic sda_oe_q,
    output logic alert_out_q,
    output logic alert_oe_q,
    input wire logic [15:0] input_voltage_code,
    input wire logic input_voltage_valid,
    input wire logic [15:0] output_voltage_code,
    input wire logic output_voltage_valid,
    input wire logic [15:0] input_current_code,
    input wire logic input_current_valid,
    input wire logic [15:0] battery_current_code,
    input wire logic battery_current_valid,
    input wire logic [15:0] chip_temperature_code,
    input wire logic chip_temperature_valid,
    input wire logic [15:0] cell_resistance_code,
    input wire logic cell_resistance_valid,
    input wire logic charger_stopped,
    input wire logic force_telemetry,
    input wire logic input_above_battery,
    output logic telemetry_on_q,
    output logic [6:0] flags_q
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic sda_q;
    tlab_state_type state_q;
    tlab_state_type next_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] cmd_q;
    logic [7:0] lo_q;
    logic [1:0] byte_cnt_q;
    logic macked_q;
    logic [15:0] rd_word_q;
    logic [15:0] rd_value;
    logic wr_q;
    logic [15:0] wr_data_q;
    logic [15:0] limit_q [0:NUM_CH-1];
    logic [15:0] en_q;
    logic [15:0] flag_word;
    logic [6:0] ch_flag;
    logic [6:0] ch_clear;
    logic [6:0] ch_valid;
    logic [15:0] ch_code [0:NUM_CH-1];
    logic cmd_is_limit;
    logic [2:0] cmd_index;

    // ----------------------------------------
    // line watcher
    // ----------------------------------------
    tlab_i2c_edges u_edges (
        .clk(clk),
        .rst(rst),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_seen(start_seen),
        .stop_seen(stop_seen),
        .sda_q(sda_q)
    );

    // ----------------------------------------
    // word protocol: write word and read word, low byte first
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            next_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            cmd_q <= 8'h00;
            lo_q <= 8'h00;
            byte_cnt_q <= 2'h0;
            macked_q <= 1'b0;
            rd_word_q <= 16'h0000;
            wr_q <= 1'b0;
            wr_data_q <= 16'h0000;
            sda_oe_q <= 1'b0;
        end
        else
        begin
            wr_q <= 1'b0;
            if (start_seen)
            begin
                state_q <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe_q <= 1'b0;
            end
            else if (stop_seen)
            begin
                state_q <= ST_IDLE;
                sda_oe_q <= 1'b0;
            end
            else
            begin
                unique case (state_q)
                    ST_IDLE:
                    begin
                        sda_oe_q <= 1'b0;
                    end
                    ST_ADDR, ST_CMD, ST_DATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_q <= {shift_q[6:0], sda_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_q == 4'h8)
                        begin
                            bit_cnt_q <= 4'h0;
                            state_q <= ST_ACK;
                            sda_oe_q <= 1'b1;
                            if (state_q == ST_ADDR)
                            begin
                                byte_cnt_q <= 2'h0;
                                if (shift_q[7:1] != DEV_ADDR)
                                begin
                                    // not ours: stay off the line until the next start
                                    state_q <= ST_IDLE;
                                    sda_oe_q <= 1'b0;
                                end
                                else if (shift_q[0])
                                begin
                                    next_q <= ST_SEND;
                                    rd_word_q <= rd_value;
                                end
                                else
                                    next_q <= ST_CMD;
                            end
                            else if (state_q == ST_CMD)
                            begin
                                cmd_q <= shift_q;
                                next_q <= ST_DATA;
                            end
                            else
                            begin
                                next_q <= ST_DATA;
                                if (byte_cnt_q == 2'h0)
                                    lo_q <= shift_q;
                                else if (byte_cnt_q == 2'h1)
                                begin
                                    wr_q <= 1'b1;
                                    wr_data_q <= {shift_q, lo_q};
                                end
                                // bytes past the word are acked and dropped
                                if (byte_cnt_q != 2'h2)
                                    byte_cnt_q <= byte_cnt_q + 2'h1;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            state_q <= next_q;
                            if (next_q == ST_SEND)
                            begin
                                shift_q <= rd_word_q[7:0];
                                sda_oe_q <= !rd_word_q[7];
                                rd_word_q <= {8'h00, rd_word_q[15:8]};
                                bit_cnt_q <= 4'h1;
                            end
                            else
                                sda_oe_q <= 1'b0;
                        end
                    end
                    ST_SEND:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_q == 4'h8)
                            begin
                                state_q <= ST_MACK;
                                sda_oe_q <= 1'b0;
                                bit_cnt_q <= 4'h0;
                            end
                            else
                            begin
                                shift_q <= {shift_q[6:0], 1'b0};
                                sda_oe_q <= !shift_q[6];
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_MACK:
                    begin
                        if (scl_rise)
                            macked_q <= !sda_q;
                        else if (scl_fall)
                        begin
                            if (macked_q)
                            begin
                                state_q <= ST_SEND;
                                shift_q <= rd_word_q[7:0];
                                sda_oe_q <= !rd_word_q[7];
                                rd_word_q <= {8'h00, rd_word_q[15:8]};
                                bit_cnt_q <= 4'h1;
                            end
                            else
                                state_q <= ST_IDLE;
                        end
                    end
                endcase
            end
        end
    end

    // open drain: the data value is always low, the enable does the work
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sda_out_q <= 1'b0;
            alert_out_q <= 1'b0;
        end
        else
        begin
            sda_out_q <= 1'b0;
            alert_out_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // register decode and read
    // ----------------------------------------
    assign cmd_is_limit = cmd_q >= CMD_INPUT_VOLTAGE_HIGH && cmd_q <= CMD_CELL_RESISTANCE_HIGH;
    assign cmd_index = 3'(cmd_q - CMD_INPUT_VOLTAGE_HIGH);

    always_comb
    begin
        flag_word = 16'h0000;
        for (int i = 0; i < NUM_CH; i++)
            flag_word[ch_bit(i)] = ch_flag[i];
    end

    // unmapped codes read as zero
    always_comb
    begin
        if (cmd_is_limit)
            rd_value = limit_q[cmd_index];
        else if (cmd_q == CMD_ALERT_ENABLE)
            rd_value = en_q;
        else if (cmd_q == CMD_ALERT_FLAGS)
            rd_value = flag_word;
        else
            rd_value = 16'h0000;
    end

    // ----------------------------------------
    // limit and enable registers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < NUM_CH; i++)
                limit_q[i] <= LIMIT_RESET;
        end
        else if (wr_q && cmd_is_limit)
            limit_q[cmd_index] <= wr_data_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            en_q <= ENABLE_RESET;
        else if (wr_q && cmd_q == CMD_ALERT_ENABLE)
            en_q <= wr_data_q & ENABLE_MASK;
    end

    // writing a zero to a flag bit clears it; ones leave it alone
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
            ch_clear[i] = wr_q && cmd_q == CMD_ALERT_FLAGS && !wr_data_q[ch_bit(i)];
    end

    // ----------------------------------------
    // telemetry enable and measurement routing
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
            telemetry_on_q <= 1'b0;
        else
            telemetry_on_q <= !charger_stopped || force_telemetry || input_above_battery;
    end

    // codes are compared raw: limits are written in the same code units
    always_comb
    begin
        ch_code[0] = input_voltage_code;
        ch_code[1] = output_voltage_code;
        ch_code[2] = output_voltage_code;
        ch_code[3] = input_current_code;
        ch_code[4] = battery_current_code;
        ch_code[5] = chip_temperature_code;
        ch_code[6] = cell_resistance_code;
        ch_valid = {cell_resistance_valid, chip_temperature_valid, battery_current_valid, input_current_valid,
                    output_voltage_valid, output_voltage_valid, input_voltage_valid} & {NUM_CH{telemetry_on_q}};
    end

    // ----------------------------------------
    // alert channels
    // ----------------------------------------
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        tlab_alert_chan #(
            .IS_HIGH(CH_IS_HIGH[g]),
            .IS_SIGNED(CH_IS_SIGNED[g])
        ) u_chan (
            .clk(clk),
            .rst(rst),
            .code(ch_code[g]),
            .limit(limit_q[g]),
            .sample(ch_valid[g]),
            .enable(en_q[ch_bit(g)]),
            .clear(ch_clear[g]),
            .flag_q(ch_flag[g])
        );
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            flags_q <= 7'h00;
            alert_oe_q <= 1'b0;
        end
        else
        begin
            flags_q <= ch_flag;
            alert_oe_q <= |(flag_word & en_q);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_vin_high_set: assert property (
        ch_valid[0] && en_q[BIT_INPUT_VOLTAGE_HIGH] && $signed(input_voltage_code) > $signed(limit_q[0])
        |=> ch_flag[0] ##1 flags_q[0])
        else $error("input voltage high flag missed");
    a_vout_low_set: assert property (
        ch_valid[1] && en_q[BIT_OUTPUT_VOLTAGE_LOW] && $signed(output_voltage_code) < $signed(limit_q[1])
        |=> ch_flag[1])
        else $error("output voltage low flag missed");
    a_vout_high_set: assert property (
        ch_valid[2] && en_q[BIT_OUTPUT_VOLTAGE_HIGH] && $signed(output_voltage_code) > $signed(limit_q[2])
        |=> ch_flag[2])
        else $error("output voltage high flag missed");
    a_iin_high_set: assert property (
        ch_valid[3] && en_q[BIT_INPUT_CURRENT_HIGH] && $signed(input_current_code) > $signed(limit_q[3])
        |=> ch_flag[3])
        else $error("input current high flag missed");
    a_ibat_low_set: assert property (
        ch_valid[4] && en_q[BIT_BATTERY_CURRENT_LOW] && $signed(battery_current_code) < $signed(limit_q[4])
        |=> ch_flag[4])
        else $error("battery current low flag missed");
    a_temp_high_set: assert property (
        ch_valid[5] && en_q[BIT_CHIP_TEMPERATURE_HIGH] && $signed(chip_temperature_code) > $signed(limit_q[5])
        |=> ch_flag[5])
        else $error("chip temperature high flag missed");
    a_res_high_set: assert property (
        ch_valid[6] && en_q[BIT_CELL_RESISTANCE_HIGH] && cell_resistance_code > limit_q[6]
        |=> ch_flag[6])
        else $error("cell resistance high flag missed");
    a_limit_write_lands: assert property (
        wr_q && cmd_q == CMD_INPUT_VOLTAGE_HIGH |=> limit_q[0] == $past(wr_data_q))
        else $error("limit write not stored");
    a_enable_gates_vin: assert property (
        !en_q[BIT_INPUT_VOLTAGE_HIGH] && !ch_flag[0] |=> !ch_flag[0])
        else $error("input voltage flag set while disabled");
    a_alert_line_follows: assert property (
        (flag_word & en_q) != 16'h0000 |=> alert_oe_q)
        else $error("alert line not pulled for enabled flag");
    a_forced_meas_on: assert property (
        charger_stopped && force_telemetry |=> telemetry_on_q)
        else $error("telemetry off while forced");
    a_auto_telemetry: assert property (
        input_above_battery |=> telemetry_on_q)
        else $error("telemetry off with input above battery");

    c_word_write: cover property (wr_q && cmd_q == CMD_ALERT_ENABLE);
    c_word_read: cover property (state_q == ST_MACK ##[1:40] state_q == ST_SEND);
    c_alert_raised: cover property ($rose(alert_oe_q));
    c_flag_cleared: cover property (ch_flag[4] ##1 !ch_flag[4]);
endmodule

// ===== dv/tlab_host_model.sv
// host side of the serial command port: word reads and writes
`timescale 1ns/1ps
module tlab_host_model
    import tlab_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a
)
(
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    logic nak = 1'b0;
    // both lines have pull-ups, so released lines float high
    assign scl = !scl_low;
    assign sda = !(sda_low || sda_oe);
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic lv(input logic cl, input logic dl, input int n);
        scl_low = cl;
        sda_low = dl;
        w(n);
    endtask
    // scl is pulled low before sda moves, so no false start or stop is seen
    task automatic start();
        lv(1, sda_low, 3);
        lv(1, 0, 3);
        lv(0, 0, 6);
        lv(0, 1, 6);
    endtask
    task automatic stop();
        lv(1, sda_low, 3);
        lv(1, 1, 3);
        lv(0, 1, 6);
        lv(0, 0, 6);
    endtask
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--)
        begin
            lv(1, sda_low, 2);
            lv(1, !d[i], 4);
            lv(0, !d[i], 6);
            r[i] = sda;
        end
    endtask
    task automatic write_word(input logic [7:0] cmd, input logic [15:0] val);
        logic [8:0] q[4];
        logic [8:0] r;
        q = '{{DEV_ADDR, 2'b01}, {cmd, 1'b1}, {val[7:0], 1'b1}, {val[15:8], 1'b1}};
        nak = 1'b0;
        start();
        foreach (q[i])
        begin
            xfer(q[i], r);
            nak |= r[0];
        end
        stop();
    endtask
    task automatic read_word(input logic [7:0] cmd, output logic [15:0] v);
        logic [8:0] r;
        logic [8:0] h;
        start();
        xfer({DEV_ADDR, 2'b01}, r);
        nak = r[0];
        xfer({cmd, 1'b1}, r);
        nak |= r[0];
        start();
        xfer({DEV_ADDR, 2'b11}, r);
        nak |= r[0];
        xfer(9'h1fe, r);
        xfer(9'h1ff, h);
        stop();
        v = {h[8:1], r[8:1]};
    endtask
endmodule

// ===== dv/telemetry_limit_alert_bank_tb.sv
// self-checking bench for the limit alert bank
`timescale 1ns/1ps
module telemetry_limit_alert_bank_tb
    import tlab_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] c[6] = '{default: 16'h0000};
    logic [5:0] v = 6'h00;
    logic [2:0] tm = 3'b000; // stopped, forced, input above battery
    logic scl;
    logic sda;
    logic sda_oe_q;
    logic sda_out_q;
    logic alert_out_q;
    logic alert_oe_q;
    logic telemetry_on_q;
    logic [6:0] flags_q;
    logic [15:0] rd;
    int err_count = 0;
    int comparisons = 0;
    // per channel: code port, limit, inside value (boundary or sign trap on channels 0 and 3 to 6), crossing value
    int pt[7] = '{0, 1, 1, 2, 3, 4, 5};
    logic [15:0] lim[7] = '{16'h0100, 16'h0010, 16'h0200, 16'h0300, 16'hff00, 16'h3000, 16'h7000};
    logic [15:0] ok[7] = '{16'h8000, 16'h0100, 16'h0100, 16'h0300, 16'hff00, 16'h9000, 16'h7000};
    logic [15:0] bad[7] = '{16'h0101, 16'hfff0, 16'h0201, 16'h0301, 16'hfe00, 16'h3001, 16'h9000};
    tlab_bank dut (.clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out_q, .sda_oe_q, .alert_out_q, .alert_oe_q,
        .input_voltage_code(c[0]), .input_voltage_valid(v[0]), .output_voltage_code(c[1]),
        .output_voltage_valid(v[1]), .input_current_code(c[2]), .input_current_valid(v[2]),
        .battery_current_code(c[3]), .battery_current_valid(v[3]), .chip_temperature_code(c[4]),
        .chip_temperature_valid(v[4]), .cell_resistance_code(c[5]), .cell_resistance_valid(v[5]),
        .charger_stopped(tm[2]), .force_telemetry(tm[1]), .input_above_battery(tm[0]), .telemetry_on_q, .flags_q);
    tlab_host_model host (.clk, .sda_oe(sda_oe_q), .scl, .sda);
    initial forever #25 clk = ~clk;
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic smp(input int p, input logic [15:0] code);
        c[p] = code;
        v[p] = 1'b1;
        host.w(1);
        v[p] = 1'b0;
        host.w(3);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        host.w(6);
        rst = 1'b0;
        host.w(2);
        for (int i = 0; i < 8; i++)
        begin
            tm = i[2:0];
            host.w(2);
            chk("telemetry on", 16'(telemetry_on_q), 16'(!tm[2] | tm[1] | tm[0]));
        end
        for (int i = 0; i < 7; i++)
        begin
            host.read_word(CMD_INPUT_VOLTAGE_HIGH + 8'(i), rd);
            chk("limit reset", rd, 16'h0000);
            host.write_word(CMD_INPUT_VOLTAGE_HIGH + 8'(i), lim[i]);
            chk("ack", 16'(host.nak), 16'h0000);
            host.read_word(CMD_INPUT_VOLTAGE_HIGH + 8'(i), rd);
            chk("limit", rd, lim[i]);
        end
        host.write_word(CMD_ALERT_ENABLE, 16'hffff);
        host.read_word(CMD_ALERT_ENABLE, rd);
        chk("enable", rd, 16'h01fc);
        host.read_word(8'h0c, rd);
        chk("unmapped", rd, 16'h0000);
        for (int i = 0; i < 7; i++)
        begin
            smp(pt[i], ok[i]);
            chk("flags inside", 16'(flags_q), 16'h0000);
            smp(pt[i], bad[i]);
            chk("flags crossed", 16'(flags_q), 16'(1 << i));
            chk("alert line", 16'(alert_oe_q), 16'h0001);
            chk("open drain values", 16'({alert_out_q, sda_out_q}), 16'h0000);
            smp(pt[i], ok[i]);
            chk("flags held", 16'(flags_q), 16'(1 << i));
            host.read_word(CMD_ALERT_FLAGS, rd);
            chk("flag word", rd, 16'(1 << (8 - i)));
            host.write_word(CMD_ALERT_FLAGS, 16'h0000);
            chk("flags cleared", 16'(flags_q), 16'h0000);
            chk("alert released", 16'(alert_oe_q), 16'h0000);
        end
        host.write_word(CMD_ALERT_ENABLE, 16'hfeff);
        smp(0, bad[0]);
        chk("gated", 16'(flags_q), 16'h0000);
        host.write_word(CMD_ALERT_ENABLE, 16'hffff);
        tm = 3'b100;
        host.w(2);
        smp(3, bad[4]);
        chk("telemetry off", 16'(flags_q), 16'h0000);
        tm = 3'b110;
        host.w(2);
        smp(3, bad[4]);
        chk("forced", 16'(flags_q), 16'h0010);
        tally_and_finish();
    end
    // the whole sequence needs about 22000 cycles
    initial
    begin
        repeat (90000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
endmodule
